// file: verilog/bar_params.svh
`ifndef BAR_PARAMS_SVH
`define BAR_PARAMS_SVH

// ==========================================================
// Configuration offsets (byte addresses of dwords)
`define HDR_DW_OFFSET 8'h0C
`define MEM_BAR_OFFSET 8'h10
`define IO_BAR_OFFSET 8'h14
`define MEM0_XLAT_OFFSET 8'h98
`define MEM0_SETUP_OFFSET 8'h9C

// ==========================================================
// Field positions
`define LAT_LSB 8
`define MEM_TYPE_LSB 1
`define MEM_PREF_BIT 3
`define MEM_BASE_LSB 12
`define IO_BASE_LSB 8

// ==========================================================
// Reset and fixed values
`define LAT_RST_PCI 8'h00
`define LAT_RST_PCIX 8'h40
`define MEM_BASE_RST 20'h00000
`define IO_BASE_RST 24'h000000
`define IO_SPACE_BIT 1'b1

`endif

// file: verilog/bar_pkg.sv
package bar_pkg;

  // Configuration request from the primary side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] data;
  } cfg_rsp_t;

  // Primary memory or I/O access to be decoded
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } acc_req_t;

  typedef struct packed {
    logic valid;
    logic csr_hit;
    logic fwd_hit;
    logic io_hit;
    logic [31:0] fwd_addr;
    logic [11:0] csr_offset;
  } claim_t;

  typedef struct packed {
    logic [7:0] lat_timer;
    logic [19:0] mem_base;
    logic [1:0] mem_type;
    logic mem_pref;
    logic [23:0] io_base;
    logic mem_en;
    logic io_en;
    cfg_rsp_t rsp;
    claim_t claim;
  } bar_state_t;

endpackage

// file: verilog/bar_window_match.sv
`timescale 1ns/1ps
module bar_window_match #(
  parameter int W = 20
) (
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] mask,
  input wire logic [W-1:0] addr,
  output logic hit,
  output logic enabled
);

  logic [W-1:0] bit_ok;

  // ==========================================================
  // Per-bit compare; unmasked bits lie inside the window
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign bit_ok[i] = !mask[i] || (base[i] == addr[i]);
    end
  endgenerate

  assign enabled = |base;
  assign hit = enabled && (&bit_ok);

endmodule

// file: verilog/primary_header_bar_decode.sv
`timescale 1ns/1ps
`include "bar_params.svh"
module primary_header_bar_decode (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reverse_mode,
  input wire logic pcix_mode,
  input wire logic [31:0] mem0_setup,
  input wire logic [31:0] mem0_xlat_base,
  input wire bar_pkg::cfg_req_t cfg_req,
  output bar_pkg::cfg_rsp_t cfg_rsp,
  input wire bar_pkg::acc_req_t acc_req,
  output bar_pkg::claim_t acc_rsp,
  output logic mem_bar_enabled,
  output logic io_bar_enabled
);
  import bar_pkg::*;

  // ==========================================================
  // Helpers

  // Byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction

  // Merge new data into bits allowed by the write mask
  function automatic logic [31:0] merge(
    input logic [31:0] cur,
    input logic [31:0] wdata,
    input logic [31:0] wmask
  );
    return (cur & ~wmask) | (wdata & wmask);
  endfunction

  // Dword select, shared by the write and read paths
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] hot;
    hot = 3'b000;
    if (addr == `HDR_DW_OFFSET) begin
      hot = 3'b001;
    end else if (addr == `MEM_BAR_OFFSET) begin
      hot = 3'b010;
    end else if (addr == `IO_BAR_OFFSET) begin
      hot = 3'b100;
    end
    return hot;
  endfunction

  // ==========================================================
  // State

  bar_state_t s_reg;
  bar_state_t s_next;

  logic [19:0] mem_mask;
  logic [31:0] mem_mask_full;
  logic [31:0] mem_word;
  logic [31:0] io_word;
  logic [31:0] hdr_word;
  logic [31:0] mem_wmask;
  logic [31:0] io_wmask;
  logic [31:0] lat_wmask;
  logic [31:0] merged;
  logic [7:0] lat_rst;
  logic mem_hit;
  logic io_hit;
  logic csr_part;
  logic [2:0] sel;

  // ==========================================================
  // Setup mask shapes the memory window

  // Setup bits 31:12 say which base bits software may write
  assign mem_mask = mem0_setup[31:`MEM_BASE_LSB];
  // Bits 11:0 are never part of the base, so 4KB is the least size
  assign mem_mask_full = {mem_mask, 12'h000};

  // ==========================================================
  // Readback words

  always_comb begin
    hdr_word = 32'h00000000;
    // Header layout, function bit and reserved byte stay zero
    hdr_word[23:16] = 8'h00;
    hdr_word[31:24] = 8'h00;
    hdr_word[`LAT_LSB +: 8] = s_reg.lat_timer;
  end

  always_comb begin
    mem_word = 32'h00000000;
    // Bit 0 memory space, bits 11:4 reserved zero
    mem_word[0] = 1'b0;
    mem_word[`MEM_TYPE_LSB +: 2] = s_reg.mem_type;
    mem_word[`MEM_PREF_BIT] = s_reg.mem_pref;
    mem_word[31:`MEM_BASE_LSB] = s_reg.mem_base;
  end

  always_comb begin
    io_word = 32'h00000000;
    io_word[0] = `IO_SPACE_BIT;
    io_word[31:`IO_BASE_LSB] = s_reg.io_base;
  end

  // ==========================================================
  // Write masks: only writable bits in enabled lanes

  // Latency byte is writable only on a reverse bridge
  assign lat_wmask = reverse_mode ?
    (lane_mask(cfg_req.be) & 32'h0000FF00) : 32'h00000000;
  // Base bits follow the setup mask, low bits never change
  assign mem_wmask = lane_mask(cfg_req.be) & mem_mask_full;
  // I/O window is 256 bytes, so all of 31:8 is writable
  assign io_wmask = lane_mask(cfg_req.be) & 32'hFFFFFF00;

  // ==========================================================
  // Window comparators

  bar_window_match #(
    .W(20)
  ) u_mem_match (
    .base(s_reg.mem_base),
    .mask(mem_mask),
    .addr(acc_req.addr[31:`MEM_BASE_LSB]),
    .hit(mem_hit),
    .enabled()
  );

  bar_window_match #(
    .W(24)
  ) u_io_match (
    .base(s_reg.io_base),
    .mask(24'hFFFFFF),
    .addr(acc_req.addr[31:`IO_BASE_LSB]),
    .hit(io_hit),
    .enabled()
  );

  // Offset bits above 4KB all zero means the register page
  assign csr_part = ((acc_req.addr & ~mem_mask_full) & 32'hFFFFF000)
    == 32'h00000000;

  // Latency reset value depends on the primary bus mode on a reverse bridge only; a forward bridge resets it to zero
  assign lat_rst = (reverse_mode && pcix_mode) ?
    `LAT_RST_PCIX : `LAT_RST_PCI;

  // Unknown offsets select nothing: writes dropped, reads miss
  assign sel = reg_sel(cfg_req.addr);

  // ==========================================================
  // Next state

  always_comb begin
    s_next = s_reg;
    merged = 32'h00000000;

    // Type and prefetch fields track the setup register
    s_next.mem_type = mem0_setup[`MEM_TYPE_LSB +: 2];
    s_next.mem_pref = mem0_setup[`MEM_PREF_BIT];
    // Bits that lose write permission fall back to read-only zero
    s_next.mem_base = s_reg.mem_base & mem_mask;

    // Forward bridge holds the latency timer at zero
    if (!reverse_mode) begin
      s_next.lat_timer = `LAT_RST_PCI;
    end

    // ---- Configuration writes
    if (cfg_req.wr) begin
      if (sel[0]) begin
        merged = merge(hdr_word, cfg_req.wdata, lat_wmask);
        s_next.lat_timer = merged[`LAT_LSB +: 8];
        if (!reverse_mode) begin
          s_next.lat_timer = `LAT_RST_PCI;
        end
      end else if (sel[1]) begin
        merged = merge(mem_word, cfg_req.wdata, mem_wmask);
        s_next.mem_base = merged[31:`MEM_BASE_LSB] & mem_mask;
      end else if (sel[2]) begin
        merged = merge(io_word, cfg_req.wdata, io_wmask);
        s_next.io_base = merged[31:`IO_BASE_LSB];
      end
    end

    // ---- Configuration reads, answered one cycle later
    s_next.rsp.valid = cfg_req.rd;
    s_next.rsp.hit = 1'b0;
    s_next.rsp.data = 32'h00000000;
    // Readback uses the current words, so a same-cycle write is not seen
    if (cfg_req.rd) begin
      if (sel[0]) begin
        s_next.rsp.hit = 1'b1;
        s_next.rsp.data = hdr_word;
      end else if (sel[1]) begin
        s_next.rsp.hit = 1'b1;
        s_next.rsp.data = mem_word;
      end else if (sel[2]) begin
        s_next.rsp.hit = 1'b1;
        s_next.rsp.data = io_word;
      end
    end

    // ---- Access decode, one result per request
    s_next.claim.valid = acc_req.valid;
    s_next.claim.csr_hit = 1'b0;
    s_next.claim.fwd_hit = 1'b0;
    s_next.claim.io_hit = 1'b0;
    s_next.claim.fwd_addr = 32'h00000000;
    s_next.claim.csr_offset = 12'h000;
    if (acc_req.valid) begin
      if (acc_req.is_io) begin
        // Zero base leaves the I/O window closed too
        s_next.claim.io_hit = io_hit;
        s_next.claim.csr_offset = {4'h0, acc_req.addr[7:0]};
      end else if (mem_hit) begin
        // An all-zero base makes mem_hit low, so nothing is claimed
        if (csr_part) begin
          s_next.claim.csr_hit = 1'b1;
          s_next.claim.csr_offset = acc_req.addr[11:0];
        end else begin
          s_next.claim.fwd_hit = 1'b1;
          // Window bits from translated base, offset from the access
          s_next.claim.fwd_addr =
            (mem0_xlat_base & mem_mask_full) |
            (acc_req.addr & ~mem_mask_full);
        end
      end
    end

    // ---- Status of the two windows
    s_next.mem_en = |s_next.mem_base;
    s_next.io_en = |s_next.io_base;

    // ---- Synchronous reset
    if (!rst_n) begin
      s_next = '0;
      s_next.lat_timer = lat_rst;
      s_next.mem_base = `MEM_BASE_RST;
      s_next.mem_type = 2'h0;
      s_next.mem_pref = 1'b0;
      s_next.io_base = `IO_BASE_RST;
    end
  end

  // ==========================================================
  // Registers

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  // ==========================================================
  // Outputs straight from the state flops

  assign cfg_rsp = s_reg.rsp;
  assign acc_rsp = s_reg.claim;
  assign mem_bar_enabled = s_reg.mem_en;
  assign io_bar_enabled = s_reg.io_en;

endmodule

// file: bench/bar_props.sv
`timescale 1ns/1ps
module bar_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reverse_mode,
  input wire logic pcix_mode,
  input wire logic [31:0] mem0_setup,
  input wire logic [31:0] mem0_xlat_base,
  input wire bar_pkg::cfg_req_t cfg_req,
  input wire bar_pkg::cfg_rsp_t cfg_rsp,
  input wire bar_pkg::acc_req_t acc_req,
  input wire bar_pkg::claim_t acc_rsp,
  input wire logic mem_bar_enabled,
  input wire logic io_bar_enabled
);
  import bar_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (cfg_req.rd |=> cfg_rsp.valid)
    else $error("read not answered");
  hdr_zero_a: assert property (
    cfg_rsp.valid && $past(cfg_req.addr) == 8'h0C
    |-> cfg_rsp.hit && cfg_rsp.data[31:16] == 16'h0000)
    else $error("header bits not zero");
  fwd_lat_a: assert property (
    cfg_rsp.valid && $past(cfg_req.addr) == 8'h0C
    && !$past(reverse_mode) && !$past(reverse_mode, 2)
    |-> cfg_rsp.data[15:8] == 8'h00)
    else $error("forward latency not zero");
  // Base read back was masked by the setup seen a cycle before the read
  mem_fixed_a: assert property (
    cfg_rsp.valid && $past(cfg_req.addr) == 8'h10
    |-> !cfg_rsp.data[0] && cfg_rsp.data[11:4] == 8'h00
    && (cfg_rsp.data[31:12] & ~$past(mem0_setup[31:12], 2)) == 20'h00000)
    else $error("memory base fixed bits wrong");
  io_fixed_a: assert property (
    cfg_rsp.valid && $past(cfg_req.addr) == 8'h14
    |-> cfg_rsp.data[7:0] == 8'h01)
    else $error("io base low bits wrong");
  acc_answer_a: assert property (
    acc_req.valid |=> acc_rsp.valid ##1
    (acc_rsp.valid == $past(acc_req.valid)))
    else $error("claim timing wrong");
  bar_off_a: assert property (
    acc_req.valid && !acc_req.is_io
    && !mem_bar_enabled && !cfg_req.wr && !$past(cfg_req.wr)
    |=> !acc_rsp.csr_hit && !acc_rsp.fwd_hit)
    else $error("disabled window claimed");
  csr_off_a: assert property (
    acc_rsp.csr_hit |-> acc_rsp.csr_offset == $past(acc_req.addr[11:0]))
    else $error("register offset wrong");
  fwd_xlat_a: assert property (
    acc_rsp.fwd_hit |-> acc_rsp.fwd_addr ==
    (($past(mem0_xlat_base) & {$past(mem0_setup[31:12]), 12'h000})
    | ($past(acc_req.addr) & ~{$past(mem0_setup[31:12]), 12'h000})))
    else $error("translated address wrong");
  one_hit_a: assert property (
    acc_rsp.valid
    |-> $onehot0({acc_rsp.csr_hit, acc_rsp.fwd_hit, acc_rsp.io_hit}))
    else $error("several claims at once");
endmodule

// file: bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  output bar_pkg::cfg_req_t cfg_req,
  input wire bar_pkg::cfg_rsp_t cfg_rsp,
  output bar_pkg::acc_req_t acc_req,
  input wire bar_pkg::claim_t acc_rsp
);
  import bar_pkg::*;
  initial begin
    cfg_req = '0;
    acc_req = '0;
  end
  // Released address, byte-enable and data lines inverted (io kept) so a stale value never passes for a request
  task cfg_wr(input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= {2'b10, a, be, d};
    @(posedge core_clk);
    cfg_req <= {2'b00, ~a, ~be, ~d};
  endtask
  task cfg_rd(input logic [7:0] a, output cfg_rsp_t r);
    @(posedge core_clk);
    cfg_req <= {2'b01, a, 4'hF, 32'h00000000};
    @(posedge core_clk);
    cfg_req <= {2'b00, ~a, 4'h0, 32'hFFFFFFFF};
    @(negedge core_clk);
    r = cfg_rsp;
  endtask
  task acc(input logic [31:0] a, input logic io, output claim_t r);
    @(posedge core_clk);
    acc_req <= {1'b1, io, a};
    @(posedge core_clk);
    acc_req <= {1'b0, io, ~a};
    @(negedge core_clk);
    r = acc_rsp;
  endtask
endmodule

// file: bench/primary_header_bar_decode_test.sv
`timescale 1ns/1ps
module primary_header_bar_decode_test;
  import bar_pkg::*;
  logic core_clk, rst_n, reverse_mode, pcix_mode;
  logic [31:0] mem0_setup, mem0_xlat_base;
  cfg_req_t cfg_req;
  cfg_rsp_t cfg_rsp;
  acc_req_t acc_req;
  claim_t acc_rsp;
  logic mem_bar_enabled, io_bar_enabled;
  int err_total, check_count;
  primary_header_bar_decode dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .reverse_mode(reverse_mode), .pcix_mode(pcix_mode),
    .mem0_setup(mem0_setup), .mem0_xlat_base(mem0_xlat_base),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .acc_req(acc_req),
    .acc_rsp(acc_rsp), .mem_bar_enabled(mem_bar_enabled),
    .io_bar_enabled(io_bar_enabled));
  host_model host_u (.core_clk(core_clk), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .acc_req(acc_req), .acc_rsp(acc_rsp));
  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask
  task rst(input logic p);
    @(posedge core_clk);
    rst_n <= 0;
    pcix_mode <= p;
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
  endtask
  task rd(input logic [7:0] a, input logic h, input logic [31:0] d);
    cfg_rsp_t r;
    host_u.cfg_rd(a, r);
    chk({r.valid, r.hit, r.data}, {1'b1, h, d});
  endtask
  task ac(input logic [31:0] a, input logic io, input logic [2:0] f,
    input logic [31:0] x);
    claim_t c;
    host_u.acc(a, io, c);
    chk({c.valid, c.csr_hit, c.fwd_hit, c.io_hit}, {1'b1, f});
    if (f != 3'b000) chk(c.fwd_hit ? c.fwd_addr : {20'h0, c.csr_offset}, x);
  endtask
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    final_report;
  end
  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 0;
    reverse_mode = 1;
    pcix_mode = 1;
    mem0_setup = 32'hFFFFE000;
    mem0_xlat_base = 32'h50000000;
    rst(1'b1);
    rd(8'h0C, 1, 32'h00004000);
    host_u.cfg_wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    rd(8'h0C, 1, 32'h0000FF00);
    host_u.cfg_wr(8'h0C, 4'hD, 32'h00000000);
    rd(8'h0C, 1, 32'h0000FF00);
    @(posedge core_clk);
    reverse_mode <= 0;
    rd(8'h0C, 1, 32'h00000000);
    host_u.cfg_wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    rd(8'h0C, 1, 32'h00000000);
    @(posedge core_clk);
    reverse_mode <= 1;
    host_u.cfg_wr(8'h0C, 4'h2, 32'h00005A00);
    rd(8'h0C, 1, 32'h00005A00);
    rst(1'b0);
    rd(8'h0C, 1, 32'h00000000);
    $display("header test done");
    rd(8'h10, 1, 32'h00000000);
    rd(8'h18, 0, 32'h00000000);
    chk(mem_bar_enabled, 1'b0);
    host_u.cfg_wr(8'h10, 4'hF, 32'hFFFFFFFF);
    rd(8'h10, 1, 32'hFFFFE000);
    host_u.cfg_wr(8'h10, 4'hF, 32'h12346000);
    mem0_setup <= 32'hFFFFE00A;
    rd(8'h10, 1, 32'h1234600A);
    chk(mem_bar_enabled, 1'b1);
    ac(32'h12346ABC, 0, 3'b100, 32'h00000ABC);
    ac(32'h12347010, 0, 3'b010, 32'h50001010);
    ac(32'h22346000, 0, 3'b000, 32'h0);
    @(posedge core_clk);
    mem0_setup <= 32'h80000000;
    host_u.cfg_wr(8'h10, 4'hF, 32'hFFFFFFFF);
    rd(8'h10, 1, 32'h80000000);
    ac(32'h80000010, 0, 3'b100, 32'h00000010);
    ac(32'h80001234, 0, 3'b010, 32'h00001234);
    host_u.cfg_wr(8'h10, 4'hF, 32'h00000000);
    rd(8'h10, 1, 32'h00000000);
    chk(mem_bar_enabled, 1'b0);
    ac(32'h00000010, 0, 3'b000, 32'h0);
    $display("memory test done");
    rd(8'h14, 1, 32'h00000001);
    chk(io_bar_enabled, 1'b0);
    ac(32'h00000010, 1, 3'b000, 32'h0);
    host_u.cfg_wr(8'h14, 4'hF, 32'hFFFFFFFF);
    rd(8'h14, 1, 32'hFFFFFF01);
    host_u.cfg_wr(8'h14, 4'hF, 32'h12345600);
    rd(8'h14, 1, 32'h12345601);
    chk(io_bar_enabled, 1'b1);
    ac(32'h123456AB, 1, 3'b001, 32'h000000AB);
    ac(32'h12345700, 1, 3'b000, 32'h0);
    $display("io test done");
    final_report;
  end
endmodule
bind primary_header_bar_decode bar_props chk_u (.core_clk(core_clk),
  .rst_n(rst_n), .reverse_mode(reverse_mode), .pcix_mode(pcix_mode),
  .mem0_setup(mem0_setup), .mem0_xlat_base(mem0_xlat_base),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .acc_req(acc_req),
  .acc_rsp(acc_rsp), .mem_bar_enabled(mem_bar_enabled),
  .io_bar_enabled(io_bar_enabled));
